// *** logic/loop_prio_config.v ***
`include "loop_prio_defines.vh"
`default_nettype none
module loop_prio_config (
   // clock and reset
   input wire sys_clk_i,
   input wire reset_i,
   // host configuration port
   input wire [6:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_write_i,
   input wire reg_read_i,
   output reg [7:0] reg_rdata_o,
   // reference state
   input wire auto_mode_i,
   input wire [3:0] ref_avail_i,
   // loop configuration to core
   output reg [1:0] capture_range_sel_o,
   output reg [1:0] phase_rate_limit_sel_o,
   output reg phase_offset_clear_en_o,
   output reg [2:0] filter_bandwidth_sel_o,
   output reg bandwidth_reserved_o,
   // selection
   output reg [1:0] selected_ref_o,
   output reg selected_valid_o
);
   // the rank layout is fixed by the two priority registers
   localparam NUM_REFS = 4;
   localparam RANK_W = 3;
   localparam HIT_CONTROL = 0;
   localparam HIT_UPPER = 1;
   localparam HIT_LOWER = 2;

   // output reset values follow the control register default
   localparam [7:0] CTL_AT_RESET = `LOOP_CONTROL_RESET;
   localparam [1:0] RANGE_AT_RESET = CTL_AT_RESET[1:0];
   localparam [1:0] RATE_AT_RESET = CTL_AT_RESET[3:2];
   localparam CLEAR_AT_RESET = CTL_AT_RESET[4];
   localparam [2:0] BW_AT_RESET = CTL_AT_RESET[7:5];
   localparam BW_RES_AT_RESET = (CTL_AT_RESET[7:5] == `BW_RESERVED);

   // register storage
   reg [7:0] loop_control;
   reg [7:0] upper_ref_priority;
   reg [7:0] lower_ref_priority;

   // host port decode
   wire [2:0] write_hit;
   wire [2:0] read_hit;
   reg [7:0] next_rdata;
   reg [7:0] next_loop_control;
   reg [7:0] next_upper_ref_priority;
   reg [7:0] next_lower_ref_priority;

   // decoded loop configuration
   reg [1:0] next_capture;
   reg [1:0] next_rate;
   reg next_clear;
   reg [2:0] next_bw;
   reg next_bw_reserved;

   // per-input rank view
   wire [11:0] ranks;
   wire [2:0] rank_code [0:3];
   wire [3:0] rank_usable;
   wire [3:0] beats_current;
   genvar g;

   // current selection and search
   reg cur_keep;
   reg [2:0] cur_rank;
   reg [1:0] next_sel;
   reg next_valid;
   reg [2:0] best_rank;
   integer i;

   // maps an address onto the register it names; unmapped gives zero
   function [2:0] addr_decode;
      input [6:0] addr;
      begin
         addr_decode = 3'h0;
         case (addr)
            `LOOP_CONTROL_ADDR: addr_decode[HIT_CONTROL] = 1'b1;
            `UPPER_REF_PRIORITY_ADDR: addr_decode[HIT_UPPER] = 1'b1;
            `LOWER_REF_PRIORITY_ADDR: addr_decode[HIT_LOWER] = 1'b1;
            default: addr_decode = 3'h0;
         endcase
      end
   endfunction

   // each priority register carries two rank codes
   function [2:0] rank_field;
      input [7:0] prio;
      input upper_half;
      begin
         rank_field = upper_half ? prio[`RANK_HI_LSB +: 3] : prio[`RANK_LO_LSB +: 3];
      end
   endfunction

   // all ones takes the input out of the search
   function rank_enabled;
      input [2:0] code;
      begin
         rank_enabled = (code != `RANK_DISABLED);
      end
   endfunction

   // strict compare: an equal rank never counts as better
   function rank_better;
      input [2:0] cand;
      input [2:0] ref_rank;
      begin
         rank_better = (cand < ref_rank);
      end
   endfunction

   // the core is told, it still gets the raw code
   function bw_is_reserved;
      input [2:0] code;
      begin
         bw_is_reserved = (code == `BW_RESERVED);
      end
   endfunction

   assign write_hit = reg_write_i ? addr_decode(reg_addr_i) : 3'h0;
   assign read_hit = reg_read_i ? addr_decode(reg_addr_i) : 3'h0;

   // input n owns ranks[3n+2:3n]
   assign ranks = {rank_field(upper_ref_priority, 1'b1),
                   rank_field(upper_ref_priority, 1'b0),
                   rank_field(lower_ref_priority, 1'b1),
                   rank_field(lower_ref_priority, 1'b0)};

   generate
      for (g = 0; g < NUM_REFS; g = g + 1) begin : g_rank
         assign rank_code[g] = ranks[g*RANK_W +: RANK_W];
         assign rank_usable[g] = ref_avail_i[g] && rank_enabled(rank_code[g]);
         assign beats_current[g] = rank_usable[g]
            && (!cur_keep || rank_better(rank_code[g], cur_rank));
      end
   endgenerate

   // reserved bits are stored as written, so reads echo them
   // writes to an unmapped address change nothing
   always @* begin
      next_loop_control = loop_control;
      if (write_hit[HIT_CONTROL]) begin
         next_loop_control = reg_wdata_i;
      end
   end

   always @* begin
      next_upper_ref_priority = upper_ref_priority;
      if (write_hit[HIT_UPPER]) begin
         next_upper_ref_priority = reg_wdata_i;
      end
   end

   always @* begin
      next_lower_ref_priority = lower_ref_priority;
      if (write_hit[HIT_LOWER]) begin
         next_lower_ref_priority = reg_wdata_i;
      end
   end

   // register storage with its defaults
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         loop_control <= `LOOP_CONTROL_RESET;
      end else begin
         loop_control <= next_loop_control;
      end
   end

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         upper_ref_priority <= `UPPER_REF_PRIORITY_RESET;
      end else begin
         upper_ref_priority <= next_upper_ref_priority;
      end
   end

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         lower_ref_priority <= `LOWER_REF_PRIORITY_RESET;
      end else begin
         lower_ref_priority <= next_lower_ref_priority;
      end
   end

   // a read beside a write to the same register returns the old value
   always @* begin
      next_rdata = 8'h00;
      case (read_hit)
         3'h1: next_rdata = loop_control;
         3'h2: next_rdata = upper_ref_priority;
         3'h4: next_rdata = lower_ref_priority;
         default: next_rdata = 8'h00;
      endcase
   end

   // read data stands until the next read
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_read_i) begin
         reg_rdata_o <= next_rdata;
      end
   end

   // loop configuration fields
   always @* begin
      next_capture = loop_control[`RANGE_LSB +: 2];
      next_rate = loop_control[`RATE_LSB +: 2];
      next_clear = loop_control[`CLEAR_BIT];
      next_bw = loop_control[`BW_LSB +: 3];
      next_bw_reserved = bw_is_reserved(loop_control[`BW_LSB +: 3]);
   end

   // one flop per field keeps every output straight from a register
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         capture_range_sel_o <= RANGE_AT_RESET;
      end else begin
         capture_range_sel_o <= next_capture;
      end
   end

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         phase_rate_limit_sel_o <= RATE_AT_RESET;
      end else begin
         phase_rate_limit_sel_o <= next_rate;
      end
   end

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         phase_offset_clear_en_o <= CLEAR_AT_RESET;
      end else begin
         phase_offset_clear_en_o <= next_clear;
      end
   end

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         filter_bandwidth_sel_o <= BW_AT_RESET;
      end else begin
         filter_bandwidth_sel_o <= next_bw;
      end
   end

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         bandwidth_reserved_o <= BW_RES_AT_RESET;
      end else begin
         bandwidth_reserved_o <= next_bw_reserved;
      end
   end

   // an unusable selection is dropped; the search then refills it
   // a dropped selection ranks as disabled, so anything usable beats it
   always @* begin
      cur_keep = selected_valid_o && rank_usable[selected_ref_o];
      cur_rank = `RANK_DISABLED;
      if (cur_keep) begin
         cur_rank = rank_code[selected_ref_o];
      end
   end

   // ascending scan with strict compare gives the lowest index on ties
   always @* begin
      next_sel = selected_ref_o;
      next_valid = cur_keep;
      best_rank = cur_rank;
      for (i = 0; i < NUM_REFS; i = i + 1) begin
         if (beats_current[i]
             && (!next_valid || rank_better(rank_code[i], best_rank))) begin
            best_rank = rank_code[i];
            next_sel = i[1:0];
            next_valid = 1'b1;
         end
      end
   end

   // outside automatic mode the selection is frozen
   // the last choice stays visible so the core can hold over on it
   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         selected_ref_o <= 2'h0;
      end else if (auto_mode_i) begin
         selected_ref_o <= next_sel;
      end
   end

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         selected_valid_o <= 1'b0;
      end else if (auto_mode_i) begin
         selected_valid_o <= next_valid;
      end
   end
endmodule
`default_nettype wire

// *** logic/loop_prio_defines.vh ***
// Contract
// - range field selects 52/130/400/3900 ppm capture
// - bits 3:2 select phase rate limit
// - bit four set clears phase offset
// - bits 7:5 select bandwidth; 111 reserved
// - input two rank, lower code wins
// - rank code 111 disables the input
// - switch revertively to better available rank
// - equal rank never displaces current selection
// - revertive across ranks, non-revertive within rank
// - bits 6:4 hold input three rank
`ifndef LOOP_PRIO_DEFINES_VH
`define LOOP_PRIO_DEFINES_VH
`define LOOP_CONTROL_ADDR 7'h3f
`define UPPER_REF_PRIORITY_ADDR 7'h40
`define LOWER_REF_PRIORITY_ADDR 7'h41
`define LOOP_CONTROL_RESET 8'h0d
`define UPPER_REF_PRIORITY_RESET 8'h32
`define LOWER_REF_PRIORITY_RESET 8'h10
`define RANGE_LSB 0
`define RATE_LSB 2
`define CLEAR_BIT 4
`define BW_LSB 5
`define RANK_LO_LSB 0
`define RANK_HI_LSB 4
`define RANK_DISABLED 3'h7
`define BW_RESERVED 3'h7
`endif

// *** sim/loop_prio_properties.sv ***
`default_nettype none
module loop_prio_properties (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // host configuration port
   input wire logic [6:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   input wire logic [7:0] reg_rdata_o,
   // reference state
   input wire logic auto_mode_i,
   input wire logic [3:0] ref_avail_i,
   // loop configuration
   input wire logic [1:0] capture_range_sel_o,
   input wire logic [1:0] phase_rate_limit_sel_o,
   input wire logic phase_offset_clear_en_o,
   input wire logic [2:0] filter_bandwidth_sel_o,
   input wire logic bandwidth_reserved_o,
   // selection
   input wire logic [1:0] selected_ref_o,
   input wire logic selected_valid_o
);
   logic [3:0] avail_q = 4'h0;
   logic auto_q = 1'b0;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   // inputs as the selector saw them one edge earlier
   always @(posedge sys_clk_i) begin
      avail_q <= ref_avail_i;
      auto_q <= auto_mode_i;
   end
   sequence lost;
      auto_mode_i && selected_valid_o && !ref_avail_i[selected_ref_o];
   endsequence
   sequence ctl_write;
      reg_write_i && reg_addr_i == 7'h3f;
   endsequence
   sequence unmapped_read;
      reg_read_i && reg_addr_i != 7'h3f && reg_addr_i != 7'h40 && reg_addr_i != 7'h41;
   endsequence
   a_lost_left: assert property (
      lost |=> !selected_valid_o || selected_ref_o != $past(selected_ref_o))
      else $error("selection kept an unavailable input");
   a_manual_hold: assert property (
      !auto_mode_i |=> $stable({selected_valid_o, selected_ref_o}))
      else $error("selection moved outside automatic mode");
   a_range_follow: assert property (
      ctl_write |=> ##1 capture_range_sel_o == $past(reg_wdata_i[1:0], 2))
      else $error("capture range differs from written code");
   a_rate_follow: assert property (
      ctl_write |=> ##1 phase_rate_limit_sel_o == $past(reg_wdata_i[3:2], 2))
      else $error("rate limit differs from written code");
   a_clear_follow: assert property (
      ctl_write |=> ##1 phase_offset_clear_en_o == $past(reg_wdata_i[4], 2))
      else $error("offset clear differs from written bit");
   a_bw_follow: assert property (
      ctl_write |=> ##1 filter_bandwidth_sel_o == $past(reg_wdata_i[7:5], 2)
         && bandwidth_reserved_o == ($past(reg_wdata_i[7:5], 2) == 3'h7))
      else $error("bandwidth differs from written code");
   a_valid_avail: assert property (
      auto_q && selected_valid_o |-> avail_q[selected_ref_o])
      else $error("selected input was not available");
   a_unmapped_zero: assert property (
      unmapped_read |=> reg_rdata_o == 8'h00)
      else $error("unmapped read returned nonzero");
endmodule
bind loop_prio_config loop_prio_properties prop_u (
   .sys_clk_i(sys_clk_i),
   .reset_i(reset_i),
   .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i),
   .reg_write_i(reg_write_i),
   .reg_read_i(reg_read_i),
   .reg_rdata_o(reg_rdata_o),
   .auto_mode_i(auto_mode_i),
   .ref_avail_i(ref_avail_i),
   .capture_range_sel_o(capture_range_sel_o),
   .phase_rate_limit_sel_o(phase_rate_limit_sel_o),
   .phase_offset_clear_en_o(phase_offset_clear_en_o),
   .filter_bandwidth_sel_o(filter_bandwidth_sel_o),
   .bandwidth_reserved_o(bandwidth_reserved_o),
   .selected_ref_o(selected_ref_o),
   .selected_valid_o(selected_valid_o)
);
`default_nettype wire

// *** sim/test_loop_prio_config.sv ***
`default_nettype none
module test_loop_prio_config;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk_i = 0, reset_i = 1, reg_write_i = 0, reg_read_i = 0, auto_mode_i = 0;
   logic [6:0] reg_addr_i = 7'h00;
   logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
   logic [3:0] ref_avail_i = 4'h0;
   logic [1:0] capture_range_sel_o, phase_rate_limit_sel_o, selected_ref_o;
   logic [2:0] filter_bandwidth_sel_o;
   logic phase_offset_clear_en_o, bandwidth_reserved_o, selected_valid_o;
   int failures = 0, check_count = 0, cyc = 0;
   loop_prio_config dut_u (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_write_i(reg_write_i),
      .reg_read_i(reg_read_i),
      .reg_rdata_o(reg_rdata_o),
      .auto_mode_i(auto_mode_i),
      .ref_avail_i(ref_avail_i),
      .capture_range_sel_o(capture_range_sel_o),
      .phase_rate_limit_sel_o(phase_rate_limit_sel_o),
      .phase_offset_clear_en_o(phase_offset_clear_en_o),
      .filter_bandwidth_sel_o(filter_bandwidth_sel_o),
      .bandwidth_reserved_o(bandwidth_reserved_o),
      .selected_ref_o(selected_ref_o),
      .selected_valid_o(selected_valid_o)
   );
   initial forever #20 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) if (++cyc == 900) begin
      failures++;
      final_report;
   end
   task automatic final_report;
      if (failures == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string n, input logic [8:0] e, s);
      check_count++;
      if (s !== e) $display("mismatch %s expected %h seen %h", n, e, s);
      if (s !== e) failures++;
   endtask
   // one access per call; strobes drop for a cycle so no edge sees two requests merge
   task automatic bus(input logic [6:0] a, input logic [7:0] d, input logic w);
      @(posedge sys_clk_i) reg_addr_i <= a;
      reg_wdata_i <= d;
      {reg_write_i, reg_read_i} <= {w, !w};
      @(posedge sys_clk_i) {reg_write_i, reg_read_i} <= 2'h0;
      @(posedge sys_clk_i) #1;
   endtask
   task automatic step(input logic [3:0] v, input logic [8:0] e);
      @(posedge sys_clk_i) ref_avail_i <= v;
      repeat (2) @(posedge sys_clk_i);
      #1 chk("select", e, {selected_valid_o, selected_ref_o});
   endtask
   task automatic t_regs;
      logic [7:0] d;
      bus(7'h41, 8'h00, 0);
      chk("prio reset", 8'h10, reg_rdata_o);
      chk("ctl reset", 9'h00d, {bandwidth_reserved_o, filter_bandwidth_sel_o,
         phase_offset_clear_en_o, phase_rate_limit_sel_o, capture_range_sel_o});
      chk("select reset", 3'h0, {selected_valid_o, selected_ref_o});
      bus(7'h42, 8'h00, 0);
      chk("unmapped", 8'h00, reg_rdata_o);
      for (int i = 0; i < 8; i++) begin
         d = {i[2:0], i[0], i[1:0], i[1:0]};
         bus(7'h3f, d, 1);
         chk("ctl", {i == 7, d}, {bandwidth_reserved_o, filter_bandwidth_sel_o,
            phase_offset_clear_en_o, phase_rate_limit_sel_o, capture_range_sel_o});
      end
      bus(7'h3f, 8'h00, 0);
      chk("readback", 8'hff, reg_rdata_o);
      bus(7'h3f, 8'h0d, 1);
   endtask
   task automatic t_select;
      @(posedge sys_clk_i) auto_mode_i <= 1;
      step(4'hf, 3'h4);
      step(4'he, 3'h5);
      step(4'hf, 3'h4);
      bus(7'h40, 8'h37, 1);
      step(4'h4, 3'h0);
      bus(7'h41, 8'h00, 1);
      step(4'h3, 3'h4);
      step(4'h2, 3'h5);
      step(4'h3, 3'h5);
      bus(7'h40, 8'h07, 1);
      bus(7'h41, 8'h11, 1);
      step(4'hb, 3'h7);
      // leaving automatic mode freezes the choice even when its input fails
      @(posedge sys_clk_i) auto_mode_i <= 0;
      step(4'h1, 3'h7);
   endtask
   task automatic t_reset;
      @(posedge sys_clk_i) reset_i <= 1;
      repeat (2) @(posedge sys_clk_i);
      reset_i <= 0;
      bus(7'h40, 8'h00, 0);
      chk("prio after reset", 8'h32, reg_rdata_o);
      chk("select after reset", 3'h0, {selected_valid_o, selected_ref_o});
   endtask
   initial begin
      repeat (10) @(posedge sys_clk_i);
      reset_i <= 0;
      t_regs;
      t_select;
      t_reset;
      final_report;
   end
endmodule
`default_nettype wire
